/* File: hw/ieb_regs.svh */
`ifndef IEB_REGS_SVH
`define IEB_REGS_SVH

// byte offsets on the wishbone slave
`define IEB_OFS_EN0      8'h00
`define IEB_OFS_EN1      8'h04
`define IEB_OFS_EN2      8'h08
`define IEB_OFS_EN3      8'h0c
`define IEB_OFS_FLAG0    8'h10
`define IEB_OFS_FLAG1    8'h14
`define IEB_OFS_FLAG2    8'h18
`define IEB_OFS_FLAG3    8'h1c
`define IEB_OFS_IST      8'h20
`define IEB_OFS_IMASK    8'h24

// implemented-bit masks per enable register
`define IEB_MASK0        16'h7fff
`define IEB_MASK1        16'hff1f
`define IEB_MASK2        16'h007f
`define IEB_MASK3        16'h0666

// can bits in register 2
`define IEB_CAN_MASK2    16'h000c

`define IEB_RST_EN       16'h0000

// status bit positions for the summary interrupt
`define IEB_IST_REQ      0
`define IEB_IST_FLAG     1

`endif

/* File: hw/ieb_pkg.sv */
`default_nettype none

package ieb_pkg;

  typedef struct packed {
    logic [15:0] r3;
    logic [15:0] r2;
    logic [15:0] r1;
    logic [15:0] r0;
  } ieb_bank_t;

  typedef struct packed {
    logic        cyc;
    logic        stb;
    logic        we;
    logic [3:0]  sel;
    logic [7:0]  adr;
    logic [31:0] dat;
  } ieb_wb_req_t;

endpackage

`default_nettype wire

/* File: hw/ieb_top.sv */
// Functional notes
// - enable bit one passes its request; zero blocks it.
// - unimplemented enable bits read zero and ignore writes.
// - all enable bits clear to zero at reset.
// - implemented enable bits are read/write and read back last write.
// - register 0 upper byte: reserved, dma1, adc, uart1 tx/rx, spi1, timer3.
// - register 0 lower byte: timer2, oc2, ic2, dma0, timer1, oc1, ic1, int0.
// - register 1 upper byte: uart2 tx/rx, int2, timer5/4, oc4/3, dma2.
// - register 1 bits 7-5 reserved; 4-0 int1, cn, cmp1, i2c1 master/slave.
// - register 2 bits 15-7 reserved; 6-0 ic4, ic3, dma3, can, can rx, spi2.
// - without can controller, can interrupts stay disabled regardless.
// - register 3: qei1 10, pwm match 9, int4 6, int3 5, i2c2 2 and 1.
// - each source has a flag that sets on request and reads one.
//
// The implementer's own choices: the address map and the Wishbone interface to the registers.
`timescale 1ns/10ps
`include "ieb_regs.svh"
`default_nettype none

module ieb_top #(
  parameter bit HAS_CAN = 1'b1
) (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic [63:0] src_req_i,
  output logic      [63:0] irq_req_o,
  output logic             irq_o
);

  localparam logic [63:0] IMPL = {`IEB_MASK3, `IEB_MASK2, `IEB_MASK1, `IEB_MASK0};
  localparam logic [63:0] CANM = {16'h0000, `IEB_CAN_MASK2, 32'h0000_0000};
  // gate mask: can sources blocked when the controller is absent
  localparam logic [63:0] GATE = HAS_CAN ? IMPL : (IMPL & ~CANM);

  ieb_pkg::ieb_bank_t en_q;
  ieb_pkg::ieb_bank_t flag_q;
  ieb_pkg::ieb_wb_req_t req;
  logic [1:0]  ist_q;
  logic [1:0]  imask_q;
  logic [63:0] req_d;
  logic [63:0] clr_d;
  logic [1:0]  ev_d;
  logic        any_req;
  logic        flag_set;
  logic        acc;
  logic        wr;
  logic        rd;
  logic [31:0] rdat_d;

  assign req = '{cyc: wb_cyc_i, stb: wb_stb_i, we: wb_we_i, sel: wb_sel_i,
                 adr: wb_adr_i, dat: wb_dat_i};
  // ack low gates a second take while the master still holds stb
  assign acc = req.cyc && req.stb && !wb_ack_o;
  assign wr  = acc && req.we;
  assign rd  = acc && !req.we;

  // merge a 16-bit write through the two low byte lanes
  function automatic logic [15:0] lane16(input logic [15:0] old, input logic [31:0] d,
                                         input logic [3:0] sel, input logic [15:0] m);
    logic [15:0] v;
    v = old;
    if (sel[0]) v[7:0] = d[7:0];
    if (sel[1]) v[15:8] = d[15:8];
    return v & m;
  endfunction

  // enable registers
  // reserved positions masked on the way in, so they can never hold a one
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      en_q <= '0;
    end else if (wr) begin
      unique case (req.adr)
        `IEB_OFS_EN0: en_q.r0 <= lane16(en_q.r0, req.dat, req.sel, `IEB_MASK0);
        `IEB_OFS_EN1: en_q.r1 <= lane16(en_q.r1, req.dat, req.sel, `IEB_MASK1);
        `IEB_OFS_EN2: en_q.r2 <= lane16(en_q.r2, req.dat, req.sel, `IEB_MASK2);
        `IEB_OFS_EN3: en_q.r3 <= lane16(en_q.r3, req.dat, req.sel, `IEB_MASK3);
        default: ;
      endcase
    end
  end

  // write-one-to-clear mask for the flag registers
  always_comb begin
    clr_d = 64'h0000_0000_0000_0000;
    if (wr) begin
      unique case (req.adr)
        `IEB_OFS_FLAG0: clr_d[15:0]  = lane16(16'h0000, req.dat, req.sel, `IEB_MASK0);
        `IEB_OFS_FLAG1: clr_d[31:16] = lane16(16'h0000, req.dat, req.sel, `IEB_MASK1);
        `IEB_OFS_FLAG2: clr_d[47:32] = lane16(16'h0000, req.dat, req.sel, `IEB_MASK2);
        `IEB_OFS_FLAG3: clr_d[63:48] = lane16(16'h0000, req.dat, req.sel, `IEB_MASK3);
        default: ;
      endcase
    end
  end

  // flags: set from sources, software writes a one to clear; set wins
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      flag_q <= '0;
    end else begin
      flag_q <= ((flag_q & ~clr_d) | src_req_i) & IMPL;
    end
  end

  assign req_d   = flag_q & en_q & GATE;
  assign any_req = |req_d;
  assign flag_set = |(src_req_i & IMPL & ~flag_q);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_req_o <= '0;
    end else begin
      irq_req_o <= req_d;
    end
  end

  always_comb begin
    ev_d = 2'b00;
    ev_d[`IEB_IST_REQ]  = any_req;
    ev_d[`IEB_IST_FLAG] = flag_set;
  end

  // sticky summary status, cleared by its read; set wins over the read clear
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ist_q <= '0;
    end else if (rd && req.adr == `IEB_OFS_IST) begin
      ist_q <= ev_d;
    end else begin
      ist_q <= ist_q | ev_d;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      imask_q <= '0;
    end else if (wr && req.adr == `IEB_OFS_IMASK && req.sel[0]) begin
      imask_q <= req.dat[1:0];
    end
  end

  // one extra cycle of latency buys a flop-driven interrupt pin
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= |(ist_q & imask_q);
    end
  end

  // read mux
  always_comb begin
    rdat_d = 32'h0000_0000;
    unique case (req.adr)
      `IEB_OFS_EN0:   rdat_d[15:0] = en_q.r0 & `IEB_MASK0;
      `IEB_OFS_EN1:   rdat_d[15:0] = en_q.r1 & `IEB_MASK1;
      `IEB_OFS_EN2:   rdat_d[15:0] = en_q.r2 & `IEB_MASK2;
      `IEB_OFS_EN3:   rdat_d[15:0] = en_q.r3 & `IEB_MASK3;
      `IEB_OFS_FLAG0: rdat_d[15:0] = flag_q.r0;
      `IEB_OFS_FLAG1: rdat_d[15:0] = flag_q.r1;
      `IEB_OFS_FLAG2: rdat_d[15:0] = flag_q.r2;
      `IEB_OFS_FLAG3: rdat_d[15:0] = flag_q.r3;
      `IEB_OFS_IST:   rdat_d[1:0]  = ist_q;
      `IEB_OFS_IMASK: rdat_d[1:0]  = imask_q;
      default:        rdat_d = 32'h0000_0000;
    endcase
  end

  // one wait-free cycle: ack the edge after the request appears
  // idle read data is zero so a stale word cannot be sampled
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= '0;
    end else begin
      wb_ack_o <= acc;
      wb_dat_o <= rd ? rdat_d : 32'h0000_0000;
    end
  end

  // reset and register storage
  a_reset_clear: assert property (@(posedge clk_i)
    ($past(rst_i) && !rst_i) |-> (en_q == '0 && irq_req_o == '0))
    else $error("enables not clear after reset");

  a_reserved_zero: assert property (@(posedge clk_i) disable iff (rst_i)
    (en_q & ~IMPL) == '0)
    else $error("reserved enable bit set");

  a_en1_gap: assert property (@(posedge clk_i) disable iff (rst_i)
    en_q.r1[7:5] == 3'b000)
    else $error("register 1 gap bit stored");

  a_en3_gap: assert property (@(posedge clk_i) disable iff (rst_i)
    (en_q.r3 & ~`IEB_MASK3) == 16'h0000)
    else $error("register 3 gap bit stored");

  a_reg2_bits: assert property (@(posedge clk_i) disable iff (rst_i)
    (en_q.r2[15:7] == 9'h000 && en_q.r0[15] == 1'b0))
    else $error("reserved bit stored");

  a_write_back: assert property (@(posedge clk_i) disable iff (rst_i)
    (wr && req.adr == `IEB_OFS_EN1 && req.sel[1:0] == 2'b11) |=>
      en_q.r1 == ($past(req.dat[15:0]) & `IEB_MASK1))
    else $error("enable write lost");

  // an enable may only move on a taken write to the enable block
  a_en_hold: assert property (@(posedge clk_i) disable iff (rst_i)
    !(wr && req.adr[7:4] == 4'h0) |=> $stable(en_q))
    else $error("enable changed without a write");

  // request forwarding
  a_enable_pass: assert property (@(posedge clk_i) disable iff (rst_i)
    (flag_q[0] && en_q[0]) |=> irq_req_o[0])
    else $error("enabled request not forwarded");

  a_disable_block: assert property (@(posedge clk_i) disable iff (rst_i)
    !en_q[8] |=> !irq_req_o[8])
    else $error("disabled request forwarded");

  a_disable_all: assert property (@(posedge clk_i) disable iff (rst_i)
    ((en_q & IMPL) == 64'h0) |=> (irq_req_o == 64'h0))
    else $error("request forwarded with all enables clear");

  a_can_gate: assert property (@(posedge clk_i) disable iff (rst_i)
    !HAS_CAN |-> (irq_req_o[35:34] == 2'b00))
    else $error("can request with no controller");

  a_req_needs_flag: assert property (@(posedge clk_i) disable iff (rst_i)
    (irq_req_o & ~$past(flag_q & en_q)) == 64'h0)
    else $error("request forwarded without flag and enable");

  // flags
  a_flag_set: assert property (@(posedge clk_i) disable iff (rst_i)
    src_req_i[48+10] |=> flag_q[48+10])
    else $error("flag did not set");

  a_flag_clear: assert property (@(posedge clk_i) disable iff (rst_i)
    (wr && req.adr == `IEB_OFS_FLAG0 && req.sel[0] && req.dat[0] && !src_req_i[0])
      |=> !flag_q[0])
    else $error("flag not cleared by write of one");

  a_flag_reserved: assert property (@(posedge clk_i) disable iff (rst_i)
    (flag_q & ~IMPL) == 64'h0)
    else $error("reserved flag bit set");

  a_flag_keep: assert property (@(posedge clk_i) disable iff (rst_i)
    (wr && req.adr == `IEB_OFS_EN0 && flag_q[0]) |=> flag_q[0])
    else $error("enable write changed flag");

  // interrupt summary
  a_ist_set: assert property (@(posedge clk_i) disable iff (rst_i)
    flag_set |=> ist_q[`IEB_IST_FLAG])
    else $error("status bit missed a new flag");

  a_ist_sticky: assert property (@(posedge clk_i) disable iff (rst_i)
    (ist_q[`IEB_IST_FLAG] && !(rd && req.adr == `IEB_OFS_IST)) |=> ist_q[`IEB_IST_FLAG])
    else $error("status bit lost without a read");

  a_irq_rise: assert property (@(posedge clk_i) disable iff (rst_i)
    (|(ist_q & imask_q)) |=> irq_o)
    else $error("interrupt not raised");

  a_irq_fall: assert property (@(posedge clk_i) disable iff (rst_i)
    !(|(ist_q & imask_q)) |=> !irq_o)
    else $error("interrupt raised with no unmasked status");

  // bus handshake
  a_ack_follow: assert property (@(posedge clk_i) disable iff (rst_i)
    acc |=> wb_ack_o)
    else $error("request not acknowledged");

  a_ack_cause: assert property (@(posedge clk_i) disable iff (rst_i)
    wb_ack_o |-> $past(acc))
    else $error("ack without a request");

  a_ack_one: assert property (@(posedge clk_i) disable iff (rst_i)
    wb_ack_o |=> !wb_ack_o)
    else $error("ack held two cycles");

  a_ack_idle: assert property (@(posedge clk_i) disable iff (rst_i)
    !req.cyc |=> !wb_ack_o)
    else $error("ack outside a cycle");

  a_rdat_idle: assert property (@(posedge clk_i) disable iff (rst_i)
    !wb_ack_o |-> (wb_dat_o == 32'h0000_0000))
    else $error("read data driven while idle");

  a_read_upper: assert property (@(posedge clk_i) disable iff (rst_i)
    wb_ack_o |-> (wb_dat_o[31:16] == 16'h0000))
    else $error("upper read half not zero");

  c_enabled_irq: cover property (@(posedge clk_i) disable iff (rst_i)
    |irq_req_o);
  c_irq_out:     cover property (@(posedge clk_i) disable iff (rst_i)
    irq_o);
  c_write_en3:   cover property (@(posedge clk_i) disable iff (rst_i)
    wr && req.adr == `IEB_OFS_EN3);
  c_flag_clear:  cover property (@(posedge clk_i) disable iff (rst_i)
    wr && req.adr == `IEB_OFS_FLAG0);
  c_status_read: cover property (@(posedge clk_i) disable iff (rst_i)
    rd && req.adr == `IEB_OFS_IST);

endmodule

`default_nettype wire

/* File: sim/ieb_src_model.sv */
`timescale 1ns/10ps
`default_nettype none

module ieb_src_model (
  input  wire logic        clk_i,
  output logic      [63:0] src_req_o
);
  initial src_req_o = 64'h0;

  // one-cycle pulse; a real source drops back to idle low at once
  task automatic raise(input int b);
    @(posedge clk_i);
    src_req_o <= 64'h1 << b;
    @(posedge clk_i);
    src_req_o <= 64'h0;
  endtask
endmodule

`default_nettype wire

/* File: sim/tb.sv */
`timescale 1ns/10ps
`default_nettype none

module tb;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic [3:0]  sel = 4'h0;
  logic [7:0]  adr = 8'h00;
  logic [31:0] dat = 32'h0, rd;
  wire logic [31:0] dat_o;
  wire logic [63:0] src, req, req_nc;
  wire logic        ack, irq;
  int          fail_count = 0;
  int          n_checks = 0;
  logic [15:0] msk [4] = '{16'h7fff, 16'hff1f, 16'h007f, 16'h0666};
  int          bits [10] = '{14, 0, 31, 20, 38, 34, 35, 58, 53, 49};

  always #5 clk_i = ~clk_i;

  ieb_top uut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_sel_i(sel), .wb_adr_i(adr), .wb_dat_i(dat), .wb_dat_o(dat_o),
    .wb_ack_o(ack), .src_req_i(src), .irq_req_o(req), .irq_o(irq));
  // variant without the can controller, fed the same traffic
  ieb_top #(.HAS_CAN(1'b0)) uut_nc (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_sel_i(sel), .wb_adr_i(adr), .wb_dat_i(dat),
    .wb_dat_o(), .wb_ack_o(), .src_req_i(src), .irq_req_o(req_nc), .irq_o());
  ieb_src_model src_m (.clk_i(clk_i), .src_req_o(src));

  task automatic complete_run();
    $display("checks %0d errors %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  task automatic chk(input logic [63:0] s, input logic [63:0] e);
    n_checks++;
    if (s !== e) begin
      fail_count++;
      $display("ERROR %0t seen %h expected %h", $time, s, e);
    end
  endtask

  task automatic wb(input logic w, input logic [7:0] a, input logic [15:0] d);
    int k;
    @(posedge clk_i);
    {cyc, stb, we, adr, dat, sel} <= {2'b11, w, a, 16'h0, d, 4'h3};
    k = 0;
    do begin
      @(posedge clk_i);
      k++;
    end while (ack !== 1'b1 && k < 20);
    rd = dat_o;
    {cyc, stb, we} <= 3'b000;
    if (k >= 20) begin
      fail_count++;
      complete_run();
    end
  endtask

  task automatic t_reset();
    chk(req, 64'h0);
    for (int i = 0; i < 4; i++) begin
      wb(1'b0, 8'(4 * i), 16'h0);
      chk(rd, 32'h0);
    end
  endtask

  task automatic t_regs();
    logic [15:0] p [3] = '{16'hffff, 16'ha5a5, 16'h0000};
    for (int i = 0; i < 4; i++) begin
      for (int j = 0; j < 3; j++) begin
        wb(1'b1, 8'(4 * i), p[j]);
        wb(1'b0, 8'(4 * i), 16'h0);
        chk(rd, {16'h0, p[j] & msk[i]});
      end
    end
    wb(1'b1, 8'h40, 16'hffff);
    wb(1'b0, 8'h40, 16'h0);
    chk(rd, 32'h0);
  endtask

  task automatic t_gate(input int b);
    logic [7:0] o;
    o = 8'(4 * (b / 16));
    src_m.raise(b);
    repeat (2) @(posedge clk_i);
    chk(req[b], 1'b0);
    wb(1'b0, o + 8'h10, 16'h0);
    chk(rd[b % 16], 1'b1);
    wb(1'b1, o, 16'h1 << (b % 16));
    repeat (2) @(posedge clk_i);
    chk(req[b], 1'b1);
    chk(req_nc[b], 1'(!(b inside {34, 35})));
    wb(1'b1, o, 16'h0);
    wb(1'b0, o + 8'h10, 16'h0);
    chk(rd[b % 16], 1'b1);
    chk(req[b], 1'b0);
    wb(1'b1, o + 8'h10, 16'h1 << (b % 16));
  endtask

  task automatic t_irq();
    int k;
    wb(1'b1, 8'h24, 16'h0002);
    // earlier traffic left status set; reading clears it
    wb(1'b0, 8'h20, 16'h0);
    src_m.raise(3);
    k = 0;
    while (irq !== 1'b1 && k < 8) begin
      @(posedge clk_i);
      k++;
    end
    if (k >= 8) begin
      fail_count++;
      complete_run();
    end
    chk(irq, 1'b1);
    wb(1'b0, 8'h20, 16'h0);
    chk(rd[1], 1'b1);
    repeat (3) @(posedge clk_i);
    chk(irq, 1'b0);
    wb(1'b1, 8'h24, 16'h0);
    wb(1'b1, 8'h10, 16'h0008);
    src_m.raise(3);
    repeat (3) @(posedge clk_i);
    chk(irq, 1'b0);
  endtask

  initial begin
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    t_reset();
    t_regs();
    foreach (bits[i]) t_gate(bits[i]);
    t_irq();
    complete_run();
  end

  initial begin
    repeat (50000) @(posedge clk_i);
    fail_count++;
    complete_run();
  end
endmodule

`default_nettype wire
